// ---- logic/emb_enable_mode.sv ----
// Enable mode bypass logic: door bypass in set-up mode via hold-to-run sequence
`timescale 1ns/1ns
`include "emb_defines.svh"

module emb_enable_mode #(
  parameter bit DRIVE_VARIANT = `EMB_VARIANT_DRIVE
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic door_guard_input,
  input  wire logic auto_contact,
  input  wire logic setup_contact,
  input  wire logic hold_to_run_switch,
  input  wire logic inching_switch,
  output logic      safety_release_output,
  output emb_pkg::emb_mode_t mode_state
);
  import emb_pkg::*;

  emb_mode_t mode;
  emb_mode_t next_mode;
  emb_seq_t  seq;
  emb_seq_t  next_seq;
  logic      next_release;
  logic      inching_last;
  logic      jog_rise;

  // Only one clean selector position counts as a mode
  function automatic emb_mode_t decode_mode(input logic a, input logic s);
    if (a && !s) return EMB_MODE_AUTO;
    if (s && !a) return EMB_MODE_SETUP;
    return EMB_MODE_NONE;
  endfunction : decode_mode

  // A fresh jog press is a low-to-high change between two scans
  function automatic logic rising(input logic now, input logic last);
    return now && !last;
  endfunction : rising

  assign next_mode = decode_mode(auto_contact, setup_contact);
  assign jog_rise  = rising(inching_switch, inching_last);

  // One clock is one scan; this instance is one function in that scan
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mode <= EMB_MODE_NONE;
    end else begin
      mode <= next_mode;
    end
  end

  // Reset to the open level of the contact, so a jog held closed through reset reads as a fresh jog edge in the first scan after reset
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      inching_last <= 1'h0;
    end else begin
      inching_last <= inching_switch;
    end
  end

  always_comb begin
    next_seq = seq;
    if (next_mode != EMB_MODE_SETUP || mode != EMB_MODE_SETUP) begin
      // A mode change restarts; a switch held on entry must reopen first
      next_seq = EMB_SEQ_IDLE;
    end else begin
      unique case (seq)
        EMB_SEQ_IDLE: begin
          if (!hold_to_run_switch) next_seq = EMB_SEQ_ARMED;
        end
        EMB_SEQ_ARMED: begin
          if (hold_to_run_switch) next_seq = EMB_SEQ_HELD;
        end
        EMB_SEQ_HELD: begin
          if (!hold_to_run_switch) next_seq = EMB_SEQ_ARMED;
          // A jog closed before the hold-to-run switch must reopen first
          else if (!DRIVE_VARIANT || jog_rise) next_seq = EMB_SEQ_RUN;
        end
        EMB_SEQ_RUN: begin
          if (!hold_to_run_switch) next_seq = EMB_SEQ_ARMED;
          else if (DRIVE_VARIANT && !inching_switch) next_seq = EMB_SEQ_HELD;
        end
      endcase
    end
  end

  // Sequence state steps once per scan
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      seq <= EMB_SEQ_IDLE;
    end else begin
      seq <= next_seq;
    end
  end

  // Auto waits for the registered mode, so the scan of a mode change never releases
  always_comb begin
    unique case (next_mode)
      EMB_MODE_AUTO:  next_release = (mode == EMB_MODE_AUTO) && door_guard_input;
      EMB_MODE_SETUP: next_release = (next_seq == EMB_SEQ_RUN);
      default:        next_release = 1'h0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      safety_release_output <= `EMB_RELEASE_RST;
    end else begin
      safety_release_output <= next_release;
    end
  end

  assign mode_state = mode;

  // Checks and covers sample once per scan, like the logic they guard
  chk_invalid_mode_off: assert property (@(posedge core_clk) disable iff (!rstn)
    (auto_contact == setup_contact) |=> !safety_release_output)
    else $error("output on with invalid mode");

  chk_auto_door_follow: assert property (@(posedge core_clk) disable iff (!rstn)
    (auto_contact && !setup_contact && door_guard_input) [*2] |=> safety_release_output)
    else $error("auto mode with door closed not enabled");

  chk_door_open_drop: assert property (@(posedge core_clk) disable iff (!rstn)
    (!setup_contact && !door_guard_input) |=> !safety_release_output)
    else $error("output on with door open outside set-up");

  chk_mode_change_drop: assert property (@(posedge core_clk) disable iff (!rstn)
    (next_mode != mode) |=> !safety_release_output)
    else $error("output on across mode change");

  chk_hold_open_drop: assert property (@(posedge core_clk) disable iff (!rstn)
    (setup_contact && !auto_contact && !hold_to_run_switch) |=> !safety_release_output)
    else $error("set-up output on with hold-to-run open");

  chk_inching_open_drop: assert property (@(posedge core_clk) disable iff (!rstn)
    (DRIVE_VARIANT && setup_contact && !auto_contact && !inching_switch)
      |=> !safety_release_output)
    else $error("drive output on with inching open");

  chk_held_on_entry: assert property (@(posedge core_clk) disable iff (!rstn)
    (mode != EMB_MODE_SETUP && next_mode == EMB_MODE_SETUP && hold_to_run_switch)
      ##1 (next_mode == EMB_MODE_SETUP && hold_to_run_switch) [*4]
      |=> !safety_release_output)
    else $error("held switch at set-up entry enabled output");

  chk_setup_release: assert property (@(posedge core_clk) disable iff (!rstn)
    (seq == EMB_SEQ_HELD && next_mode == EMB_MODE_SETUP && hold_to_run_switch
      && (jog_rise || !DRIVE_VARIANT)) |=> safety_release_output)
    else $error("valid set-up sequence did not enable output");

  chk_reset_off: assert property (@(posedge core_clk)
    !rstn |=> !safety_release_output && seq == EMB_SEQ_IDLE)
    else $error("reset did not clear output");

  chk_jog_before_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    (DRIVE_VARIANT && seq == EMB_SEQ_ARMED && hold_to_run_switch && inching_switch)
      ##1 (next_mode == EMB_MODE_SETUP && hold_to_run_switch && inching_switch) [*2]
      |=> !safety_release_output)
    else $error("jog closed before hold-to-run enabled output");

  chk_idle_outside_setup: assert property (@(posedge core_clk) disable iff (!rstn)
    (mode != EMB_MODE_SETUP) |-> (seq == EMB_SEQ_IDLE))
    else $error("sequence state kept outside set-up");

  chk_release_in_run: assert property (@(posedge core_clk) disable iff (!rstn)
    (safety_release_output && mode == EMB_MODE_SETUP) |-> (seq == EMB_SEQ_RUN))
    else $error("set-up output on outside the run step");

  chk_reset_mode: assert property (@(posedge core_clk)
    !rstn |=> (mode_state == EMB_MODE_NONE))
    else $error("reset did not clear the mode");

  chk_armed_needs_open: assert property (@(posedge core_clk) disable iff (!rstn)
    (seq == EMB_SEQ_IDLE && hold_to_run_switch) |=> (seq != EMB_SEQ_ARMED))
    else $error("sequence armed while hold-to-run held");

  chk_setup_follows_run: assert property (@(posedge core_clk) disable iff (!rstn)
    (next_mode == EMB_MODE_SETUP) |=> (safety_release_output == (seq == EMB_SEQ_RUN)))
    else $error("set-up output not set by the sequence alone");

  chk_run_needs_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    (seq == EMB_SEQ_RUN) |-> $past(hold_to_run_switch))
    else $error("run step without hold-to-run held");

  chk_run_needs_jog: assert property (@(posedge core_clk) disable iff (!rstn)
    (DRIVE_VARIANT && seq == EMB_SEQ_RUN) |-> $past(inching_switch))
    else $error("drive run step without jog closed");

  chk_auto_leave_drop: assert property (@(posedge core_clk) disable iff (!rstn)
    (mode == EMB_MODE_AUTO && next_mode != EMB_MODE_AUTO) |=> !safety_release_output)
    else $error("output kept after leaving auto mode");

  // Scenario covers
  cov_auto_enable: cover property (@(posedge core_clk) disable iff (!rstn)
    mode == EMB_MODE_AUTO && safety_release_output);

  cov_setup_enable: cover property (@(posedge core_clk) disable iff (!rstn)
    mode == EMB_MODE_SETUP && safety_release_output);

  cov_mode_change: cover property (@(posedge core_clk) disable iff (!rstn)
    safety_release_output ##1 (mode != $past(mode)));

  cov_invalid: cover property (@(posedge core_clk) disable iff (!rstn)
    auto_contact && setup_contact);

  cov_jog_blocked: cover property (@(posedge core_clk) disable iff (!rstn)
    DRIVE_VARIANT && seq == EMB_SEQ_HELD && inching_switch && inching_last);
endmodule : emb_enable_mode

// ---- logic/emb_defines.svh ----
// Constants for the enable mode bypass logic
`ifndef EMB_DEFINES_SVH
`define EMB_DEFINES_SVH
`define EMB_VARIANT_ENERGY 1'h0
`define EMB_VARIANT_DRIVE  1'h1
`define EMB_RELEASE_RST    1'h0
`endif

// ---- logic/emb_pkg.sv ----
// Types for the enable mode bypass logic
package emb_pkg;
  typedef enum logic [1:0] {
    EMB_MODE_NONE,
    EMB_MODE_AUTO,
    EMB_MODE_SETUP
  } emb_mode_t;

  typedef enum logic [1:0] {
    EMB_SEQ_IDLE,
    EMB_SEQ_ARMED,
    EMB_SEQ_HELD,
    EMB_SEQ_RUN
  } emb_seq_t;
endpackage : emb_pkg

// ---- test/emb_panel.sv ----
// Operator panel model: selector contacts and hold-to-run switch
`timescale 1ns/1ns
module emb_panel (
  input  wire logic [1:0] sel,
  input  wire logic       pressed,
  output logic            auto_contact,
  output logic            setup_contact,
  output logic            hold_to_run_switch
);
  // Sel 1 auto, 2 set-up; 0 and 3 stand for a broken selector
  assign auto_contact       = sel[0];
  assign setup_contact      = sel[1];
  assign hold_to_run_switch = pressed;
endmodule : emb_panel

// ---- test/emb_enable_mode_test.sv ----
// Self-checking bench for the enable mode bypass logic
`timescale 1ns/1ns
`define CHK(nm, e, v) begin checks_done++; if ((v) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %b got %b", nm, e, v); end end
module emb_enable_mode_test;
  import emb_pkg::*;
  logic       core_clk, auto_contact, setup_contact, hold_to_run_switch, drv_out, nrg_out;
  logic       rstn = 1'h0, door_guard_input = 1'h0, inching_switch = 1'h0, pressed = 1'h0;
  logic [1:0] sel = 2'h0;
  emb_mode_t  mode;
  int         bad_count, checks_done;
  emb_panel i_panel (.sel(sel), .pressed(pressed), .auto_contact(auto_contact),
    .setup_contact(setup_contact), .hold_to_run_switch(hold_to_run_switch));
  emb_enable_mode #(.DRIVE_VARIANT(1'h1)) i_dut (.core_clk(core_clk), .rstn(rstn),
    .door_guard_input(door_guard_input), .auto_contact(auto_contact),
    .setup_contact(setup_contact), .hold_to_run_switch(hold_to_run_switch),
    .inching_switch(inching_switch), .safety_release_output(drv_out), .mode_state(mode));
  // Energy variant shares every input, so one sequence judges both variants
  emb_enable_mode #(.DRIVE_VARIANT(1'h0)) i_dut_nrg (.core_clk(core_clk), .rstn(rstn),
    .door_guard_input(door_guard_input), .auto_contact(auto_contact),
    .setup_contact(setup_contact), .hold_to_run_switch(hold_to_run_switch),
    .inching_switch(inching_switch), .safety_release_output(nrg_out), .mode_state());
  task look(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : look
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task t_auto;
    @(posedge core_clk) door_guard_input <= 1'h1;
    look(2); `CHK("none_out", 1'h0, nrg_out)
    @(posedge core_clk) sel <= 2'h1;
    look(2); `CHK("auto_out", 1'h1, drv_out)
    `CHK("auto_mode", EMB_MODE_AUTO, mode)
    @(posedge core_clk) door_guard_input <= 1'h0;
    look(1); `CHK("door_open", 1'h0, nrg_out)
    @(posedge core_clk) door_guard_input <= 1'h1;
    look(1); `CHK("door_last", 1'h1, nrg_out)
    @(posedge core_clk) sel <= 2'h3;
    look(2); `CHK("both_on", 1'h0, drv_out)
    `CHK("both_mode", EMB_MODE_NONE, mode)
  endtask : t_auto
  task t_setup;
    // Switch already held when set-up becomes valid: the reverse order
    @(posedge core_clk) pressed <= 1'h1;
    sel <= 2'h2;
    door_guard_input <= 1'h0;
    look(4); `CHK("early_hold", 1'h0, nrg_out)
    `CHK("setup_mode", EMB_MODE_SETUP, mode)
    @(posedge core_clk) inching_switch <= 1'h1;
    look(2); `CHK("early_jog", 1'h0, drv_out)
    @(posedge core_clk) pressed <= 1'h0;
    look(1);
    @(posedge core_clk) pressed <= 1'h1;
    look(2); `CHK("nrg_rel", 1'h1, nrg_out)
    `CHK("jog_stale", 1'h0, drv_out)
    @(posedge core_clk) inching_switch <= 1'h0;
    look(1); `CHK("jog_open", 1'h0, drv_out)
    @(posedge core_clk) inching_switch <= 1'h1;
    look(1); `CHK("jog_rel", 1'h1, drv_out)
    @(posedge core_clk) inching_switch <= 1'h0;
    look(1); `CHK("jog_drop", 1'h0, drv_out)
    `CHK("nrg_keep", 1'h1, nrg_out)
    @(posedge core_clk) pressed <= 1'h0;
    look(1); `CHK("hold_drop", 1'h0, nrg_out)
    @(posedge core_clk) pressed <= 1'h1;
    look(2); `CHK("rearm", 1'h1, nrg_out)
    @(posedge core_clk) sel <= 2'h1;
    door_guard_input <= 1'h1;
    look(1); `CHK("chg_auto", 1'h0, nrg_out)
    look(0); `CHK("auto_back", 1'h1, drv_out)
    @(posedge core_clk) sel <= 2'h2;
    door_guard_input <= 1'h0;
    look(3); `CHK("chg_setup", 1'h0, nrg_out)
    @(posedge core_clk) pressed <= 1'h0;
    look(1);
    @(posedge core_clk) pressed <= 1'h1;
    look(2); `CHK("fresh_seq", 1'h1, nrg_out)
    @(posedge core_clk) rstn <= 1'h0;
    look(1); `CHK("rst_out", 1'h0, nrg_out)
    @(posedge core_clk) rstn <= 1'h1;
    look(3); `CHK("rst_seq", 1'h0, nrg_out)
  endtask : t_setup
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'h1;
    t_auto();
    t_setup();
    close_out();
  end
  initial begin
    #20000;
    bad_count++;
    close_out();
  end
endmodule : emb_enable_mode_test
